// >>> core/tci_pkg.sv
// shared constants and types for the touch controller two-wire register port
package tci_pkg;
    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;

    // ------------------------------------------------------------------
    // bus address and framing
    // ------------------------------------------------------------------
    localparam logic [4:0] SLAVE_ADDR_HI = 5'h0B; // fixed upper five address bits
    localparam logic [3:0] BIT_LAST = 4'h8;       // eight bits per byte
    localparam logic [2:0] TX_LAST = 3'h7;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [2:0] TX_ZERO = 3'h0;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] PTR_RESET = 10'h000;
    localparam logic [ADDR_W-1:0] REG_POWER_AND_SEQUENCE_CONTROL = 10'h000;
    localparam logic [ADDR_W-1:0] REG_STAGE_CALIBRATION_ENABLE = 10'h001;
    localparam logic [ADDR_W-1:0] REG_CONTROL_WORD_TWO = 10'h002;
    localparam logic [ADDR_W-1:0] REG_CONTROL_WORD_THREE = 10'h003;
    localparam logic [ADDR_W-1:0] REG_CONTROL_WORD_FOUR = 10'h004;
    localparam logic [ADDR_W-1:0] REG_INTERRUPT_ENABLE_FIRST = 10'h005;
    localparam logic [ADDR_W-1:0] REG_INTERRUPT_ENABLE_SECOND = 10'h006;
    localparam logic [ADDR_W-1:0] REG_INTERRUPT_ENABLE_THIRD = 10'h007;
    localparam logic [ADDR_W-1:0] REG_INTERRUPT_STATUS_FIRST = 10'h008;
    localparam logic [ADDR_W-1:0] REG_INTERRUPT_STATUS_SECOND = 10'h009;
    localparam logic [ADDR_W-1:0] REG_INTERRUPT_STATUS_THIRD = 10'h00A;
    localparam logic [ADDR_W-1:0] BANK2_FIRST = 10'h080;
    localparam logic [ADDR_W-1:0] BANK2_LAST = 10'h0DF;
    localparam logic [ADDR_W-1:0] BANK3_FIRST = 10'h0E0;
    localparam logic [ADDR_W-1:0] ADDR_TOP = 10'h3FF;
    localparam int CTRL_WORDS = 8;
    localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;

    // ------------------------------------------------------------------
    // write byte phases and states
    // ------------------------------------------------------------------
    localparam logic [1:0] WR_PTR_HI = 2'h0;
    localparam logic [1:0] WR_PTR_LO = 2'h1;
    localparam logic [1:0] WR_DATA_HI = 2'h2;
    localparam logic [1:0] WR_DATA_LO = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_RX,
        ST_ACK_RX,
        ST_TX,
        ST_ACK_TX
    } tci_state_e;
endpackage

// >>> core/tci_pin_sync.sv
// two-flop synchroniser with edge detection for one pin
`timescale 1ns/10ps
module tci_pin_sync
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta;
    logic sync;
    logic prev;

    // ------------------------------------------------------------------
    // crossing
    // ------------------------------------------------------------------
    // meta feeds only sync; edges look at sync and prev
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            meta <= 1'b1;
            sync <= 1'b1;
            prev <= 1'b1;
        end
        else
        begin
            meta <= pin;
            sync <= meta;
            prev <= sync;
        end
    end

    // edge decode
    assign level = sync;
    assign rise = sync & ~prev;
    assign fall = ~sync & prev;
endmodule

// >>> core/tci_i2c_regs.sv
// two-wire slave register port with pointer, readback and result bank
`timescale 1ns/10ps
//
// Contract
// RULE1: master loads the register pointer with a write before reading.
// RULE2: master then issues repeated start or stop, then a read.
// RULE3: each register read returns high byte first, then low byte.
// RULE4: pointer advances after each register read; reads continue consecutively.
// RULE5: master ends a read with not-acknowledge then stop.
// RULE6: at the top address reads repeat the last register, no wrap.
// RULE7: host first writes configuration bank 0x080 to 0x0DF contiguously.
// RULE8: host then writes control 0x000 to 0x007, keeping 0x001 zero.
// RULE9: suggested control start-up values; 0x005 to 0x007 are application enables.
// RULE10: host afterwards writes 0x001 separately with the stage calibration mask.
// RULE11: host reads the interrupt status register matching its output configuration.
// RULE12: host repeats that status read on each interrupt.
// RULE13: result bank refreshes on each completed sequence and stays host readable; a result write in the same cycle as a host bank write is dropped.
// RULE14: configuration and result banks undefined until configuration is written.
// RULE15: host programs the configuration bank right after power-up.
// RULE16: device answers bus address 01011 plus two select pins.
// RULE17: stop returns to idle and clears the pointer to zero.
// RULE18: register address is two bytes high first; only ten low bits used.
// RULE19: data line driven only for acknowledges and addressed read data.
module tci_i2c_regs
#(
    parameter logic [9:0] MAX_ADDR = tci_pkg::ADDR_TOP
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic bus_addr_select_low,
    input wire logic bus_addr_select_high,
    input wire logic [15:0] int_status_first,
    input wire logic [15:0] int_status_second,
    input wire logic [15:0] int_status_third,
    input wire logic result_we,
    input wire logic [9:0] result_addr,
    input wire logic [15:0] result_data,
    output logic [15:0] power_and_sequence_control,
    output logic [15:0] stage_calibration_enable,
    output logic config_valid
);
    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic scl_s, scl_rise, scl_fall, sda_s, sda_rise, sda_fall, sel_low, sel_high;

    tci_pin_sync u_scl (.clk(clk), .reset_n(reset_n), .pin(scl_i), .level(scl_s), .rise(scl_rise), .fall(scl_fall));
    tci_pin_sync u_sda (.clk(clk), .reset_n(reset_n), .pin(sda_i), .level(sda_s), .rise(sda_rise), .fall(sda_fall));
    tci_pin_sync u_sel0 (.clk(clk), .reset_n(reset_n), .pin(bus_addr_select_low), .level(sel_low), .rise(), .fall());
    tci_pin_sync u_sel1 (.clk(clk), .reset_n(reset_n), .pin(bus_addr_select_high), .level(sel_high), .rise(), .fall());

    // ------------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------------
    tci_pkg::tci_state_e state, next_state;
    logic [3:0] bit_cnt;
    logic [2:0] tx_cnt;
    logic [7:0] shift;
    logic [7:0] tx_byte;
    logic [7:0] tx_lo;
    logic [7:0] data_hi;
    logic [1:0] ptr_hi;
    logic [1:0] wr_idx;
    logic [9:0] ptr;
    logic tx_hi_phase;
    logic nack;
    logic wr_at_max;
    logic [15:0] ctrl [0:tci_pkg::CTRL_WORDS-1];
    logic [15:0] mem [0:1023]; // banks 2 and 3; no reset, contents undefined until written

    // register read mux, used for the current and the next pointer
    function automatic logic [15:0] read_word(input logic [9:0] a);
        logic [15:0] w;
        w = tci_pkg::READ_ZERO;
        if (a <= tci_pkg::REG_INTERRUPT_ENABLE_THIRD)
            w = ctrl[a[2:0]];
        else if (a == tci_pkg::REG_INTERRUPT_STATUS_FIRST)
            w = int_status_first;
        else if (a == tci_pkg::REG_INTERRUPT_STATUS_SECOND)
            w = int_status_second;
        else if (a == tci_pkg::REG_INTERRUPT_STATUS_THIRD)
            w = int_status_third;
        else if (a >= tci_pkg::BANK2_FIRST)
            w = mem[a];
        return w;
    endfunction

    // ------------------------------------------------------------------
    // event decode
    // ------------------------------------------------------------------
    // bus conditions: data moving while clock is high
    wire start_det = scl_s & sda_fall;
    wire stop_det = scl_s & sda_rise;
    wire byte_done = scl_fall & (bit_cnt == tci_pkg::BIT_LAST);
    wire addr_match = (shift[7:3] == tci_pkg::SLAVE_ADDR_HI) && (shift[2:1] == {sel_high, sel_low}); // [RULE16]
    wire rx_done = (state == tci_pkg::ST_RX) && byte_done;
    wire ptr_load = rx_done && (wr_idx == tci_pkg::WR_PTR_LO);
    wire host_wr = rx_done && (wr_idx == tci_pkg::WR_DATA_LO) && !wr_at_max;
    wire host_ctrl_wr = host_wr && (ptr <= tci_pkg::REG_INTERRUPT_ENABLE_THIRD);
    wire host_mem_wr = host_wr && (ptr >= tci_pkg::BANK2_FIRST);
    wire host_cfg_wr = host_mem_wr && (ptr <= tci_pkg::BANK2_LAST);
    // results wait for configuration; a host write in the same cycle takes the port
    wire res_wr = result_we && config_valid && (result_addr >= tci_pkg::BANK3_FIRST) && !host_mem_wr; // [RULE14]
    wire word_sent = (state == tci_pkg::ST_ACK_TX) && scl_fall && !tx_hi_phase;
    wire [9:0] ptr_inc = (ptr == MAX_ADDR) ? ptr : ptr + 10'h001; // saturate, never wrap [RULE6]
    wire [15:0] rd_cur = read_word(ptr);
    wire [15:0] rd_next = read_word(ptr_inc);
    wire [7:0] rd_cur_hi = rd_cur[15:8];
    wire tx_start = (state == tci_pkg::ST_ACK_ADDR) && scl_fall && shift[0];

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            tci_pkg::ST_IDLE: next_state = tci_pkg::ST_IDLE;
            tci_pkg::ST_ADDR:
                if (byte_done)
                    next_state = addr_match ? tci_pkg::ST_ACK_ADDR : tci_pkg::ST_IDLE; // [RULE16]
            tci_pkg::ST_ACK_ADDR:
                if (scl_fall)
                    next_state = shift[0] ? tci_pkg::ST_TX : tci_pkg::ST_RX;
            tci_pkg::ST_RX:
                if (byte_done)
                    next_state = tci_pkg::ST_ACK_RX;
            tci_pkg::ST_ACK_RX:
                if (scl_fall)
                    next_state = tci_pkg::ST_RX;
            tci_pkg::ST_TX:
                if (scl_fall && tx_cnt == tci_pkg::TX_LAST)
                    next_state = tci_pkg::ST_ACK_TX;
            tci_pkg::ST_ACK_TX:
                if (scl_fall)
                    next_state = nack ? tci_pkg::ST_IDLE : tci_pkg::ST_TX; // master not-acknowledge ends reading
            default: next_state = tci_pkg::ST_IDLE;
        endcase
        if (start_det)
            next_state = tci_pkg::ST_ADDR;
        if (stop_det)
            next_state = tci_pkg::ST_IDLE; // [RULE17]
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            state <= tci_pkg::ST_IDLE;
        else
            state <= next_state;
    end

    // ------------------------------------------------------------------
    // bit and byte shifting
    // ------------------------------------------------------------------
    // receive on rising clock, transmit changes on falling clock
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            bit_cnt <= tci_pkg::BIT_ZERO;
            tx_cnt <= tci_pkg::TX_ZERO;
            shift <= 8'h00;
            nack <= 1'b0;
        end
        else if (start_det || (scl_fall && next_state != state))
        begin
            bit_cnt <= tci_pkg::BIT_ZERO;
            tx_cnt <= tci_pkg::TX_ZERO;
            nack <= 1'b0;
        end
        else
        begin
            if (scl_rise && (state == tci_pkg::ST_ADDR || state == tci_pkg::ST_RX))
            begin
                shift <= {shift[6:0], sda_s};
                bit_cnt <= bit_cnt + 4'h1;
            end
            if (scl_rise && state == tci_pkg::ST_ACK_TX)
                nack <= sda_s;
            if (scl_fall && state == tci_pkg::ST_TX)
                tx_cnt <= tx_cnt + 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // read data path
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            tx_byte <= 8'hFF;
            tx_lo <= 8'hFF;
            tx_hi_phase <= 1'b1;
        end
        else if (tx_start)
        begin
            tx_byte <= rd_cur_hi; // high byte goes out first [RULE3]
            tx_lo <= rd_cur[7:0];
            tx_hi_phase <= 1'b1;
        end
        else if (state == tci_pkg::ST_TX && scl_fall)
        begin
            tx_byte <= {tx_byte[6:0], 1'b1}; // ones shifted in keep the line released
            if (tx_cnt == tci_pkg::TX_LAST)
                tx_byte <= 8'hFF;
        end
        else if (state == tci_pkg::ST_ACK_TX && scl_fall && !nack)
        begin
            if (tx_hi_phase)
                tx_byte <= tx_lo; // [RULE3]
            else
            begin
                tx_byte <= rd_next[15:8]; // following register, read through ptr_inc in the cycle the pointer advances [RULE4]
                tx_lo <= rd_next[7:0];
            end
            tx_hi_phase <= !tx_hi_phase;
        end
    end

    // ------------------------------------------------------------------
    // pointer and write phases
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            ptr <= tci_pkg::PTR_RESET;
            ptr_hi <= 2'h0;
            wr_idx <= tci_pkg::WR_PTR_HI;
            data_hi <= 8'h00;
            wr_at_max <= 1'b0;
        end
        else if (stop_det)
        begin
            ptr <= tci_pkg::PTR_RESET; // [RULE17]
            wr_idx <= tci_pkg::WR_PTR_HI;
            wr_at_max <= 1'b0;
        end
        else if (start_det)
            wr_idx <= tci_pkg::WR_PTR_HI;
        else if (rx_done)
        begin
            case (wr_idx)
                tci_pkg::WR_PTR_HI:
                begin
                    ptr_hi <= shift[1:0]; // upper six bits ignored [RULE18]
                    wr_idx <= tci_pkg::WR_PTR_LO;
                end
                tci_pkg::WR_PTR_LO:
                begin
                    ptr <= {ptr_hi, shift}; // [RULE18]
                    wr_at_max <= 1'b0;
                    wr_idx <= tci_pkg::WR_DATA_HI;
                end
                tci_pkg::WR_DATA_HI:
                begin
                    data_hi <= shift;
                    wr_idx <= tci_pkg::WR_DATA_LO;
                end
                default:
                begin
                    wr_idx <= tci_pkg::WR_DATA_HI;
                    if (host_wr)
                    begin
                        ptr <= ptr_inc;
                        wr_at_max <= (ptr == MAX_ADDR); // later words are discarded
                    end
                end
            endcase
        end
        else if (word_sent)
            ptr <= ptr_inc; // [RULE4] [RULE6]
    end

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    // control words reset; status words are read-only inputs
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < tci_pkg::CTRL_WORDS; i++)
                ctrl[i] <= tci_pkg::CTRL_RESET;
            config_valid <= 1'b0;
        end
        else
        begin
            if (host_ctrl_wr)
                ctrl[ptr[2:0]] <= {data_hi, shift};
            if (host_cfg_wr)
                config_valid <= 1'b1; // [RULE14]
        end
    end

    // single write port shared by host and conversion results
    always_ff @(posedge clk)
    begin
        if (host_mem_wr)
            mem[ptr] <= {data_hi, shift};
        else if (res_wr)
            mem[result_addr] <= result_data; // [RULE13]
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // open-drain: only ever pulls low, oe covers acks and read bits
    assign sda_o = 1'b0;
    assign sda_oe = (state == tci_pkg::ST_ACK_ADDR) || (state == tci_pkg::ST_ACK_RX)
                    || (state == tci_pkg::ST_TX && !tx_byte[7]); // [RULE19]
    assign power_and_sequence_control = ctrl[tci_pkg::REG_POWER_AND_SEQUENCE_CONTROL[2:0]];
    assign stage_calibration_enable = ctrl[tci_pkg::REG_STAGE_CALIBRATION_ENABLE[2:0]];

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_lo_byte_end;
        (state == tci_pkg::ST_ACK_TX) && scl_fall && !tx_hi_phase;
    endsequence

    sequence s_hi_byte_end;
        (state == tci_pkg::ST_ACK_TX) && scl_fall && tx_hi_phase && !nack;
    endsequence

    a_stop_ptr_clear: assert property (stop_det |=> (ptr == tci_pkg::PTR_RESET) // [RULE17]
                                       && (state == tci_pkg::ST_IDLE))
        else $error("pointer not cleared by stop");
    a_addr_reject: assert property ((state == tci_pkg::ST_ADDR) && byte_done && !addr_match && !stop_det // [RULE16]
                                    |=> !sda_oe)
        else $error("foreign address acknowledged");
    a_hi_first: assert property (tx_start |=> tx_byte == $past(rd_cur_hi)) // [RULE3]
        else $error("first read byte is not the high byte");
    a_lo_second: assert property (s_hi_byte_end |=> tx_byte == $past(tx_lo)) // [RULE3]
        else $error("second read byte is not the low byte");
    a_ptr_advance: assert property (s_lo_byte_end and (ptr != MAX_ADDR) |=> ptr == $past(ptr) + 10'h001) // [RULE4]
        else $error("pointer did not advance after read");
    a_ptr_no_wrap: assert property (s_lo_byte_end and (ptr == MAX_ADDR) |=> ptr == MAX_ADDR) // [RULE6]
        else $error("pointer wrapped at top address");
    a_ptr_load: assert property (ptr_load |=> ptr == {$past(ptr_hi), $past(shift)}) // [RULE18]
        else $error("pointer load used wrong bits");
    a_result_store: assert property (res_wr |=> mem[$past(result_addr)] == $past(result_data)) // [RULE13]
        else $error("result word not stored");
    a_cfg_first: assert property ($rose(config_valid) |-> $past(host_cfg_wr)) // [RULE14]
        else $error("configuration valid without configuration write");
    a_release_stop: assert property (stop_det |=> !sda_oe [*2]) // [RULE19]
        else $error("data line driven after stop");
endmodule

// >>> testbench/tci_host_model.sv
// two-wire bus master model that stands on the far side of the register port
`timescale 1ns/10ps
module tci_host_model
(
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low,
    output logic obs_valid,
    output logic [8:0] obs_data,
    output int clash
);
    // bus idles released; clock stands high outside frames
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
        obs_valid = 1'b0;
        obs_data = 9'h000;
        clash = 0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // works from idle and as a repeated start after a low clock
    task automatic start_cond();
        tick(4);
        sda_low <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b0;
    endtask

    task automatic stop_cond();
        tick(4);
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b0;
        tick(4);
    endtask

    // 4 clk hold, 4 clk setup, sample mid-high: 16 clk per bit
    task automatic bit_xfer(input logic b, output logic r);
        tick(4);
        sda_low <= ~b;
        tick(4);
        scl <= 1'b1;
        tick(4);
        r = sda;
        tick(4);
        scl <= 1'b0;
    endtask

    task automatic report(input logic [8:0] v);
        obs_data <= v;
        obs_valid <= 1'b1;
        @(posedge clk);
        obs_valid <= 1'b0;
    endtask

    // a master bit read back low means the device pulled where it must not
    task automatic wbyte(input logic [7:0] v);
        logic r;
        int i;
        for (i = 7; i >= 0; i--)
        begin
            bit_xfer(v[i], r);
            if (r !== v[i]) clash++;
        end
        bit_xfer(1'b1, r);
        report({1'b1, 7'h00, r});
    endtask

    task automatic rbyte(input logic ack);
        logic [7:0] v;
        logic r;
        int i;
        for (i = 7; i >= 0; i--)
            bit_xfer(1'b1, v[i]);
        bit_xfer(~ack, r);
        report({1'b0, v});
    endtask
endmodule

// >>> testbench/tci_i2c_regs_tb.sv
// self-checking bench for the two-wire register port
`timescale 1ns/10ps
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin n_fail++; \
    $display("unexpected %s exp %h got %h", what, exp, got); end end
module tci_i2c_regs_tb;
    localparam logic [9:0] MAXA = 10'h0E1; // short top pointer to reach saturation
    localparam int LIMIT = 80000;
    logic clk, reset_n, sel_lo, sel_hi, result_we, cfg_ok, sda_o, sda_oe;
    logic [15:0] st1, st2, st3, res_data, ctrl0, ctrl1, w;
    logic [9:0] res_addr;
    logic scl, host_low, obs_valid;
    logic [8:0] obs_data, e;
    logic [15:0] mem [0:1023];
    logic [8:0] exp_q [$];
    int clash, n_fail, compares, cyc, seed, i, s;
    wire sda;

    // pull-up wire: low when either party pulls
    assign sda = ~(host_low | (sda_oe & ~sda_o));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    tci_i2c_regs #(.MAX_ADDR(MAXA)) DUT (.clk(clk), .reset_n(reset_n), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .bus_addr_select_low(sel_lo), .bus_addr_select_high(sel_hi),
        .int_status_first(st1), .int_status_second(st2), .int_status_third(st3), .result_we(result_we),
        .result_addr(res_addr), .result_data(res_data), .power_and_sequence_control(ctrl0),
        .stage_calibration_enable(ctrl1), .config_valid(cfg_ok));

    tci_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low), .obs_valid(obs_valid),
        .obs_data(obs_data), .clash(clash));

    // ----------
    // bus tasks
    // ----------
    task automatic wr(input logic [7:0] v, input logic nack);
        exp_q.push_back({1'b1, 7'h00, nack});
        host.wbyte(v);
    endtask

    // junk in the upper pointer bits must be ignored
    task automatic set_ptr(input logic [9:0] a);
        host.start_cond();
        wr({tci_pkg::SLAVE_ADDR_HI, sel_hi, sel_lo, 1'b0}, 1'b0);
        wr({6'h2A, a[9:8]}, 1'b0);
        wr(a[7:0], 1'b0);
    endtask

    task automatic write_seq(input logic [9:0] a, input int n);
        int k;
        set_ptr(a);
        for (k = 0; k < n; k++)
        begin
            wr(mem[a + k][15:8], 1'b0);
            wr(mem[a + k][7:0], 1'b0);
        end
        host.stop_cond();
    endtask

    // brk puts a stop before the read, which clears the pointer
    task automatic read_seq(input logic [9:0] a, input int n, input logic brk);
        int k;
        logic [9:0] p;
        set_ptr(a);
        if (brk) host.stop_cond();
        host.start_cond();
        wr({tci_pkg::SLAVE_ADDR_HI, sel_hi, sel_lo, 1'b1}, 1'b0);
        p = brk ? tci_pkg::PTR_RESET : a;
        for (k = 0; k < n; k++)
        begin
            exp_q.push_back({1'b0, mem[p][15:8]});
            host.rbyte(1'b1);
            exp_q.push_back({1'b0, mem[p][7:0]});
            host.rbyte(k != n - 1);
            if (p < MAXA) p++;
        end
        host.stop_cond();
    endtask

    task automatic no_answer();
        host.start_cond();
        wr({tci_pkg::SLAVE_ADDR_HI, ~sel_hi, sel_lo, 1'b0}, 1'b1);
        host.stop_cond();
    endtask

    task automatic stop_test();
        $display("counts: compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // oldest note against each observed byte or acknowledge
    always @(posedge clk)
    begin
        if (obs_valid === 1'b1)
        begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 9'h1FF;
            `CHK("bus byte", e, obs_data)
        end
    end

    // hang guard, sized for about 50k cycles of traffic
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            n_fail++;
            stop_test();
        end
    end

    // main sequence
    initial
    begin
        seed = 32'h95fa;
        {reset_n, sel_lo, sel_hi, result_we} = 4'h0;
        {st1, st2, st3, res_data, res_addr} = 74'h0;
        {n_fail, compares, cyc} = 0;
        for (i = 0; i < 1024; i++) mem[i] = 16'h0000;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("config_valid", 1'b0, cfg_ok)
        read_seq(10'h000, 8, 1'b0);
        $display("test reset_values done");
        for (i = 128; i < 224; i++) mem[i] = 16'($random(seed));
        write_seq(10'h080, 96);
        {mem[0], mem[2], mem[3], mem[4]} = {16'h82B2, 16'h3230, 16'h0419, 16'h0340};
        for (i = 5; i < 8; i++) mem[i] = 16'($random(seed));
        write_seq(10'h000, 8);
        `CHK("calibration mask", 16'h0000, ctrl1)
        `CHK("power control", 16'h82B2, ctrl0)
        `CHK("config_valid", 1'b1, cfg_ok)
        mem[1] = 16'h0FFF;
        write_seq(10'h001, 1);
        `CHK("calibration mask", 16'h0FFF, ctrl1)
        read_seq(10'h000, 8, 1'b0);
        read_seq(10'h07E, 4, 1'b0);
        $display("test startup done");
        // every strap setting, status refreshed between reads
        for (s = 0; s < 4; s++)
        begin
            for (i = 8; i < 11; i++) mem[i] = 16'($random(seed));
            {sel_hi, sel_lo} <= 2'(s);
            {st1, st2, st3} <= {mem[8], mem[9], mem[10]};
            repeat (4) @(posedge clk);
            no_answer();
            read_seq(10'h008, 3, 1'b0);
        end
        read_seq(10'h003, 2, 1'b1);
        $display("test straps_status done");
        // result writes: below the bank is dropped, inside is kept
        for (i = 223; i < 226; i++)
        begin
            w = 16'($random(seed));
            if (i > 223) mem[i] = w;
            res_addr <= 10'(i);
            res_data <= w;
            result_we <= 1'b1;
            @(posedge clk);
        end
        result_we <= 1'b0;
        read_seq(10'h0DE, 6, 1'b0);
        repeat (4) @(posedge clk);
        `CHK("data line drive", 1'b0, sda_oe)
        `CHK("bus clash", 0, clash)
        `CHK("pending notes", 0, exp_q.size())
        $display("test result_bank done");
        stop_test();
    end
endmodule
